// ### design/dsof_pkg.sv
package dsof_pkg;
  localparam int ADDR_W = 8;
  localparam int FREQ_W = 16;
  localparam int CODE_W = 5;
  localparam int N_TERM = 4;
  localparam int N_FLAG = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_ACCEL_THR_A = 8'h00;
  localparam logic [7:0] OFS_DECEL_THR_A = 8'h04;
  localparam logic [7:0] OFS_ACCEL_THR_B = 8'h08;
  localparam logic [7:0] OFS_DECEL_THR_B = 8'h0c;
  localparam logic [7:0] OFS_OL_LEVEL_ONE = 8'h10;
  localparam logic [7:0] OFS_OL_LEVEL_TWO = 8'h14;
  localparam logic [7:0] OFS_PID_DEV_LEVEL = 8'h18;
  localparam logic [7:0] OFS_TERM_SEL = 8'h1c;
  localparam logic [7:0] OFS_RELAY_CFG = 8'h20;
  localparam logic [7:0] OFS_FLAGS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  // Thresholds in 0.01 Hz, overload levels in 0.1 x rated, PID level in 0.1 %
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [15:0] THR_MAX = 16'h9c40;
  localparam logic [15:0] THR_FINE_LIMIT = 16'h2710;
  localparam logic [15:0] THR_COARSE_STEP = 16'h000a;
  localparam logic [7:0] OL_LEVEL_RESET = 8'h0a;
  localparam logic [7:0] OL_LEVEL_MAX = 8'h14;
  localparam logic [7:0] OL_LEVEL_DIV = 8'h0a;
  localparam logic [15:0] PID_LEVEL_RESET = 16'h001e;
  localparam logic [15:0] PID_LEVEL_MAX = 16'h03e8;
  // Hysteresis in percent of maximum frequency
  localparam logic [15:0] HYST_ON_PCT = 16'h0001;
  localparam logic [15:0] HYST_OFF_PCT = 16'h0002;
  localparam logic [15:0] PCT_DIV = 16'h0064;
  // Field positions
  localparam int TERM_SEL_STRIDE = 8;
  localparam int RELAY_ALARM_SEL_LSB = 0;
  localparam int RELAY_RUN_SEL_LSB = 8;
  localparam int RELAY_ALARM_POL_BIT = 16;
  localparam int RELAY_RUN_POL_BIT = 17;
  // Flag vector bit positions
  localparam int FLG_CONST_SPEED = 0;
  localparam int FLG_OVER_A = 1;
  localparam int FLG_AT_A = 2;
  localparam int FLG_OVER_B = 3;
  localparam int FLG_AT_B = 4;
  localparam int FLG_OL_ONE = 5;
  localparam int FLG_OL_TWO = 6;
  localparam int FLG_PID_DEV = 7;
  localparam int FLG_ALARM = 8;
  localparam int FLG_RUN = 9;
  // Output selection codes
  localparam logic [4:0] CODE_RUN = 5'h00;
  localparam logic [4:0] CODE_CONST_SPEED = 5'h01;
  localparam logic [4:0] CODE_OVER_A = 5'h02;
  localparam logic [4:0] CODE_OL_ONE = 5'h03;
  localparam logic [4:0] CODE_PID_DEV = 5'h04;
  localparam logic [4:0] CODE_ALARM = 5'h05;
  localparam logic [4:0] CODE_AT_A = 5'h06;
  localparam logic [4:0] CODE_OVER_B = 5'h13;
  localparam logic [4:0] CODE_AT_B = 5'h14;
  localparam logic [4:0] CODE_OL_TWO = 5'h15;
  localparam logic [31:0] TERM_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] RELAY_CFG_RESET = 32'h0000_0005;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### design/dsof_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - Constant-speed flag on at set minus 1% of max, off below set minus 2%.
// - At-threshold flags accelerating: on at threshold minus 1%, off above threshold plus 2%.
// - At-threshold flags decelerating: on at threshold plus 1%, off below threshold minus 2%.
// - Code 01 drives terminal once output reaches active commanded frequency.
// - Codes 2 and 19 show output above first or second threshold pair.
// - Codes 6 and 20 show output sitting at first or second threshold pair.
// - Four arrival thresholds, reset 0.00 Hz, 0 to 400 Hz, coarser above 100 Hz.
// - Codes 3 and 21 flag current above overload level one or two.
// - Overload levels are 0.0 to 2.0 times rated current, reset 1.0.
// - Code 4 flags PID error above the deviation level.
// - PID deviation level 0.0 to 100.0 percent, reset 3.0 percent.
// - Code 5 alarm latches on a fault until alarm reset; inactive after reset.
// - Alarm relay selection defaults to the alarm flag; any terminal may take it.
// - Each open-collector terminal outputs the flag its selection code names.
// - Code 0 flags run mode, including DC braking; off when stopped.
// - Per-relay polarity 0 closes normally-open pair on active flag, 1 inverts.
module dsof_top import dsof_pkg::*; #(
  parameter int FW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dsof_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dsof_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [FW-1:0] output_freq,
  input wire logic [FW-1:0] active_cmd_freq,
  input wire logic [FW-1:0] max_freq,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic run_mode,
  input wire logic [15:0] output_current,
  input wire logic [15:0] rated_current,
  input wire logic signed [15:0] pid_error,
  input wire logic fault_event,
  input wire logic alarm_reset,
  output logic [dsof_pkg::N_TERM-1:0] oc_terminal,
  output logic alarm_relay_contact_a,
  output logic alarm_relay_contact_b,
  output logic run_relay_contact_a,
  output logic run_relay_contact_b,
  output logic irq
);
  import dsof_pkg::*;

  // Flag bit of a selection code; unknown codes select nothing
  function automatic logic pick_flag(input logic [CODE_W-1:0] code, input logic [N_FLAG-1:0] f);
    logic r;
    r = 1'b0;
    case (code)
      CODE_RUN: r = f[FLG_RUN];
      CODE_CONST_SPEED: r = f[FLG_CONST_SPEED];
      CODE_OVER_A: r = f[FLG_OVER_A];
      CODE_OL_ONE: r = f[FLG_OL_ONE];
      CODE_PID_DEV: r = f[FLG_PID_DEV];
      CODE_ALARM: r = f[FLG_ALARM];
      CODE_AT_A: r = f[FLG_AT_A];
      CODE_OVER_B: r = f[FLG_OVER_B];
      CODE_AT_B: r = f[FLG_AT_B];
      CODE_OL_TWO: r = f[FLG_OL_TWO];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d, araddr_c;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, awready_q, awready_d, wready_q, wready_d;
  logic arready_q, arready_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, rd_word;
  logic wr_en, wr_mapped, rd_mapped;

  logic [15:0] thr_q [4];
  logic [15:0] thr_d [4];
  logic [7:0] ol_lvl_q [2];
  logic [7:0] ol_lvl_d [2];
  logic [15:0] pid_lvl_q, pid_lvl_d;
  logic [31:0] term_sel_q, term_sel_d, relay_cfg_q, relay_cfg_d;
  logic [N_FLAG-1:0] flag_q, flag_d, stat_q, stat_d, mask_q, mask_d;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_IRQ_MASK);
  endfunction

  assign wr_en = aw_held_q && w_held_q && !bvalid_q;
  assign wr_mapped = is_mapped(awaddr_q);
  assign araddr_c = s_axi_araddr;
  assign rd_mapped = is_mapped(araddr_c);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr_c)
      OFS_ACCEL_THR_A: rd_word = {16'h0000, thr_q[0]};
      OFS_DECEL_THR_A: rd_word = {16'h0000, thr_q[1]};
      OFS_ACCEL_THR_B: rd_word = {16'h0000, thr_q[2]};
      OFS_DECEL_THR_B: rd_word = {16'h0000, thr_q[3]};
      OFS_OL_LEVEL_ONE: rd_word = {24'h00_0000, ol_lvl_q[0]};
      OFS_OL_LEVEL_TWO: rd_word = {24'h00_0000, ol_lvl_q[1]};
      OFS_PID_DEV_LEVEL: rd_word = {16'h0000, pid_lvl_q};
      OFS_TERM_SEL: rd_word = term_sel_q;
      OFS_RELAY_CFG: rd_word = relay_cfg_q;
      OFS_FLAGS: rd_word = {22'h00_0000, flag_q};
      OFS_IRQ_STATUS: rd_word = {22'h00_0000, stat_q};
      OFS_IRQ_MASK: rd_word = {22'h00_0000, mask_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    arready_d = arready_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_en) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // One write in flight: channels reopen only after the response is taken
    awready_d = !aw_held_d && !bvalid_d && !wr_en;
    wready_d = !w_held_d && !bvalid_d && !wr_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      arready_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      arready_q <= (arready_q || rvalid_q) ? arready_d : !rvalid_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // ---------------- Settings registers ----------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Out-of-range writes saturate rather than fault, so the comparators never see nonsense
  function automatic logic [15:0] clamp_thr(input logic [15:0] v);
    logic [15:0] r;
    r = (v > THR_MAX) ? THR_MAX : v;
    if (r >= THR_FINE_LIMIT) r = r - (r % THR_COARSE_STEP);
    return r;
  endfunction

  logic [31:0] wmerged;
  logic [N_FLAG-1:0] flag_rise;

  always_comb begin
    wmerged = merge(rd_word_at_aw(), wdata_q, wstrb_q);
    thr_d = thr_q;
    ol_lvl_d = ol_lvl_q;
    pid_lvl_d = pid_lvl_q;
    term_sel_d = term_sel_q;
    relay_cfg_d = relay_cfg_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_en && wr_mapped) begin
      case (awaddr_q)
        OFS_ACCEL_THR_A: thr_d[0] = clamp_thr(wmerged[15:0]);
        OFS_DECEL_THR_A: thr_d[1] = clamp_thr(wmerged[15:0]);
        OFS_ACCEL_THR_B: thr_d[2] = clamp_thr(wmerged[15:0]);
        OFS_DECEL_THR_B: thr_d[3] = clamp_thr(wmerged[15:0]);
        OFS_OL_LEVEL_ONE: ol_lvl_d[0] = (wmerged[7:0] > OL_LEVEL_MAX) ? OL_LEVEL_MAX : wmerged[7:0];
        OFS_OL_LEVEL_TWO: ol_lvl_d[1] = (wmerged[7:0] > OL_LEVEL_MAX) ? OL_LEVEL_MAX : wmerged[7:0];
        OFS_PID_DEV_LEVEL: pid_lvl_d = (wmerged[15:0] > PID_LEVEL_MAX) ? PID_LEVEL_MAX : wmerged[15:0];
        OFS_TERM_SEL: term_sel_d = wmerged;
        OFS_RELAY_CFG: relay_cfg_d = wmerged;
        OFS_IRQ_STATUS: stat_d = stat_q & ~wmerged[N_FLAG-1:0];
        OFS_IRQ_MASK: mask_d = wmerged[N_FLAG-1:0];
        default: stat_d = stat_q;
      endcase
    end
    // A flag edge in the clearing cycle still sets its bit
    stat_d = stat_d | flag_rise;
  end

  function automatic logic [31:0] rd_word_at_aw();
    logic [31:0] r;
    r = 32'h0000_0000;
    case (awaddr_q)
      OFS_ACCEL_THR_A: r = {16'h0000, thr_q[0]};
      OFS_DECEL_THR_A: r = {16'h0000, thr_q[1]};
      OFS_ACCEL_THR_B: r = {16'h0000, thr_q[2]};
      OFS_DECEL_THR_B: r = {16'h0000, thr_q[3]};
      OFS_OL_LEVEL_ONE: r = {24'h00_0000, ol_lvl_q[0]};
      OFS_OL_LEVEL_TWO: r = {24'h00_0000, ol_lvl_q[1]};
      OFS_PID_DEV_LEVEL: r = {16'h0000, pid_lvl_q};
      OFS_TERM_SEL: r = term_sel_q;
      OFS_RELAY_CFG: r = relay_cfg_q;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_q <= '{default: THR_RESET};
      ol_lvl_q <= '{default: OL_LEVEL_RESET};
      pid_lvl_q <= PID_LEVEL_RESET;
      term_sel_q <= TERM_SEL_RESET;
      relay_cfg_q <= RELAY_CFG_RESET;
      mask_q <= '0;
      stat_q <= '0;
    end else begin
      thr_q <= thr_d;
      ol_lvl_q <= ol_lvl_d;
      pid_lvl_q <= pid_lvl_d;
      term_sel_q <= term_sel_d;
      relay_cfg_q <= relay_cfg_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
    end
  end

  // ---------------- Status flags ----------------
  logic signed [FW+1:0] f_s, set_s, f_on, f_off;
  logic [23:0] cur_x, lvl_x [2];
  logic [15:0] pid_abs;

  always_comb begin
    f_s = (FW+2)'(output_freq);
    set_s = (FW+2)'(active_cmd_freq);
    // Product taken at 32 bits so a large maximum frequency cannot wrap
    f_on = (FW+2)'(32'(max_freq) * 32'(HYST_ON_PCT) / 32'(PCT_DIV));
    f_off = (FW+2)'(32'(max_freq) * 32'(HYST_OFF_PCT) / 32'(PCT_DIV));
    cur_x = 24'(output_current) * 24'(OL_LEVEL_DIV);
    lvl_x[0] = 24'(rated_current) * 24'(ol_lvl_q[0]);
    lvl_x[1] = 24'(rated_current) * 24'(ol_lvl_q[1]);
    pid_abs = pid_error[15] ? 16'(-pid_error) : 16'(pid_error);
    flag_d = flag_q;
    if (flag_q[FLG_CONST_SPEED]) flag_d[FLG_CONST_SPEED] = !(f_s < set_s - f_off);
    else flag_d[FLG_CONST_SPEED] = f_s >= set_s - f_on;
    for (int p = 0; p < 2; p++) begin
      logic signed [FW+1:0] acc_s, dec_s;
      acc_s = (FW+2)'(thr_q[2*p]);
      dec_s = (FW+2)'(thr_q[2*p+1]);
      if (accelerating && !flag_q[FLG_OVER_A + 2*p] && f_s >= acc_s - f_on) flag_d[FLG_OVER_A + 2*p] = 1'b1;
      if (decelerating && flag_q[FLG_OVER_A + 2*p] && f_s < dec_s - f_off) flag_d[FLG_OVER_A + 2*p] = 1'b0;
      if (accelerating) begin
        if (flag_q[FLG_AT_A + 2*p]) flag_d[FLG_AT_A + 2*p] = !(f_s > acc_s + f_off);
        else flag_d[FLG_AT_A + 2*p] = (f_s >= acc_s - f_on) && (f_s <= acc_s + f_off);
      end else if (decelerating) begin
        if (flag_q[FLG_AT_A + 2*p]) flag_d[FLG_AT_A + 2*p] = !(f_s < dec_s - f_off);
        else flag_d[FLG_AT_A + 2*p] = (f_s <= dec_s + f_on) && (f_s >= dec_s - f_off);
      end
    end
    // overload notices, equal level holds state
    for (int k = 0; k < 2; k++) begin
      if (cur_x > lvl_x[k]) flag_d[FLG_OL_ONE + k] = 1'b1;
      else if (cur_x < lvl_x[k]) flag_d[FLG_OL_ONE + k] = 1'b0;
    end
    if (pid_abs > pid_lvl_q) flag_d[FLG_PID_DEV] = 1'b1;
    else if (pid_abs < pid_lvl_q) flag_d[FLG_PID_DEV] = 1'b0;
    // alarm latch, a new fault beats the reset
    if (fault_event) flag_d[FLG_ALARM] = 1'b1;
    else if (alarm_reset) flag_d[FLG_ALARM] = 1'b0;
    flag_d[FLG_RUN] = run_mode;
  end

  assign flag_rise = flag_d & ~flag_q;

  // ---------------- Terminal routing ----------------
  logic [N_TERM-1:0] oc_d;
  logic alarm_act, run_act, irq_d;

  always_comb begin
    for (int t = 0; t < N_TERM; t++) begin
      oc_d[t] = pick_flag(term_sel_q[t*TERM_SEL_STRIDE +: CODE_W], flag_q);
    end
    alarm_act = pick_flag(relay_cfg_q[RELAY_ALARM_SEL_LSB +: CODE_W], flag_q) ^ relay_cfg_q[RELAY_ALARM_POL_BIT];
    run_act = pick_flag(relay_cfg_q[RELAY_RUN_SEL_LSB +: CODE_W], flag_q) ^ relay_cfg_q[RELAY_RUN_POL_BIT];
    irq_d = |(stat_q & mask_q);
  end

  // registered flags and outputs, cleared by reset except the b contacts, which reset sets to 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= '0;
      oc_terminal <= '0;
      alarm_relay_contact_a <= 1'b0;
      alarm_relay_contact_b <= 1'b1;
      run_relay_contact_a <= 1'b0;
      run_relay_contact_b <= 1'b1;
      irq <= 1'b0;
    end else begin
      flag_q <= flag_d;
      oc_terminal <= oc_d;
      alarm_relay_contact_a <= alarm_act;
      alarm_relay_contact_b <= !alarm_act;
      run_relay_contact_a <= run_act;
      run_relay_contact_b <= !run_act;
      irq <= irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// ### dv/dsof_relay_watch.sv
`timescale 1ns/1ps
// Outside interlock watching one relay contact
module dsof_relay_watch #(
  parameter int HOLD_CYC = 4
) (
  input wire logic aclk,
  input wire logic contact_closed,
  output logic trip_seen
);
  int cnt = 0;
  // chatter tolerant
  // A closure only counts once it has held, so bounce at power cycling is ignored
  always @(posedge aclk) begin
    cnt <= contact_closed ? ((cnt < HOLD_CYC) ? cnt + 1 : cnt) : 0;
  end
  assign trip_seen = (cnt >= HOLD_CYC);
endmodule

// ### dv/dsof_top_sva.sv
`timescale 1ns/1ps
module dsof_status_sva import dsof_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dsof_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [dsof_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic run_mode,
  input wire logic fault_event,
  input wire logic alarm_reset,
  input wire logic [dsof_pkg::N_TERM-1:0] oc_terminal,
  input wire logic alarm_relay_contact_a,
  input wire logic alarm_relay_contact_b,
  input wire logic run_relay_contact_a,
  input wire logic run_relay_contact_b,
  input wire logic irq
);
  logic run1_q, run2_q, alm_q, alm2_q, term_tch_q, relay_tch_q, mask_tch_q;
  logic aw_hs;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  // Reference flags only hold while the routing registers keep their reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {run1_q, run2_q, alm_q, alm2_q} <= 4'h0;
      {term_tch_q, relay_tch_q, mask_tch_q} <= 3'h0;
    end else begin
      run1_q <= run_mode;
      run2_q <= run1_q;
      alm_q <= fault_event || (alm_q && !alarm_reset);
      alm2_q <= alm_q;
      term_tch_q <= term_tch_q || (aw_hs && s_axi_awaddr == OFS_TERM_SEL);
      relay_tch_q <= relay_tch_q || (aw_hs && s_axi_awaddr == OFS_RELAY_CFG);
      mask_tch_q <= mask_tch_q || (aw_hs && s_axi_awaddr == OFS_IRQ_MASK);
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_bad_rd;
    s_rd_taken ##0 s_axi_araddr > 8'h2c;
  endsequence
  sequence s_err_answer;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endsequence
  a_alarm_relay_latch: assert property (!relay_tch_q |-> alarm_relay_contact_a == alm2_q)
    else $error("alarm relay does not follow latched fault");
  a_run_on_terminals: assert property (!term_tch_q |-> oc_terminal == {4{run2_q}})
    else $error("default terminals do not show run mode");
  a_run_relay_default: assert property (!relay_tch_q |-> run_relay_contact_a == run2_q)
    else $error("run relay default routing wrong");
  a_alarm_pair_opposite: assert property (alarm_relay_contact_a != alarm_relay_contact_b)
    else $error("alarm contacts not complementary");
  a_run_pair_opposite: assert property (run_relay_contact_a != run_relay_contact_b)
    else $error("run contacts not complementary");
  a_irq_stays_masked: assert property (!mask_tch_q |-> !irq)
    else $error("irq raised with mask clear");
  a_reset_clears_outputs: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> oc_terminal == 4'h0 && !irq && !alarm_relay_contact_a && alarm_relay_contact_b)
    else $error("outputs not cleared by reset");
  a_read_answer_next: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bad_read_error: assert property (s_bad_rd |=> s_err_answer)
    else $error("unmapped read not refused");
  a_read_one_only: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
endmodule
bind dsof_top dsof_status_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .run_mode,
  .fault_event, .alarm_reset, .oc_terminal, .alarm_relay_contact_a, .alarm_relay_contact_b,
  .run_relay_contact_a, .run_relay_contact_b, .irq);

// ### dv/drive_status_output_flags_tb_top.sv
`timescale 1ns/1ps
module drive_status_output_flags_tb_top;
  import dsof_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, accelerating = 0, decelerating = 0, run_mode = 0;
  logic fault_event = 0, alarm_reset = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, oc_terminal;
  logic [15:0] output_freq = 16'h0, active_cmd_freq = 16'h1770, max_freq = 16'h2ee0;
  logic [15:0] output_current = 16'h0, rated_current = 16'h0064;
  logic signed [15:0] pid_error = 16'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, trip;
  logic alarm_relay_contact_a, alarm_relay_contact_b, run_relay_contact_a, run_relay_contact_b;
  int errors = 0, total_checks = 0, cycles = 0;
  logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0a, 32'h0a, 32'h1e, 32'h0, 32'h5};
  logic [15:0] fq [8] = '{16'haf0, 16'hc1c, 16'hce4, 16'h16f9, 16'h16a8, 16'h1644, 16'h834, 16'h6a4};
  logic [1:0] md [8] = '{2'b10, 2'b10, 2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b01};
  logic [2:0] ex [8] = '{3'b000, 3'b011, 3'b001, 3'b101, 3'b101, 3'b001, 3'b011, 3'b000};
  dsof_top #(.FW(16)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .output_freq,
    .active_cmd_freq, .max_freq, .accelerating, .decelerating, .run_mode, .output_current, .rated_current,
    .pid_error, .fault_event, .alarm_reset, .oc_terminal, .alarm_relay_contact_a, .alarm_relay_contact_b,
    .run_relay_contact_a, .run_relay_contact_b, .irq);
  dsof_relay_watch #(.HOLD_CYC(4)) u_watch (.aclk(aclk), .contact_closed(alarm_relay_contact_a),
    .trip_seen(trip));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Response readies stay high, so back-to-back calls never retoggle them; a wait ends on the response valid or at the 20000-cycle timeout
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask
  task automatic pulse(input logic clr);
    if (clr) alarm_reset <= 1;
    else fault_event <= 1;
    @(posedge aclk);
    alarm_reset <= 0;
    fault_event <= 0;
    settle();
  endtask
  // Walk one frequency profile; bit positions say where each flag was routed
  task automatic arrival(input int ob, input int ab, input int cb);
    logic [3:0] e;
    for (int i = 0; i < 8; i++) begin
      output_freq <= fq[i];
      {accelerating, decelerating} <= md[i];
      settle();
      e = 4'h0;
      e[ob] = ex[i][0];
      e[ab] = ex[i][1];
      e[cb] = ex[i][2];
      chk({28'h0, oc_terminal}, {28'h0, e}, "arrival");
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4), d, RESP_OKAY);
      chk(d, rst_tab[i], "reset value");
    end
    $display("test reset values done");
    rd(8'h30, d, RESP_SLVERR);
    chk(d, 32'h0, "unmapped read data");
    wr(8'h02, 32'h1234, RESP_SLVERR);
    wr(OFS_FLAGS, 32'hffff_ffff, RESP_OKAY);
    $display("test bad access done");
    wr(OFS_IRQ_MASK, 32'h0000_0100, RESP_OKAY);
    pulse(1'b0);
    chk({31'h0, alarm_relay_contact_a}, 32'h1, "alarm latched");
    chk({31'h0, irq}, 32'h1, "irq raised");
    repeat (4) @(posedge aclk);
    chk({31'h0, trip}, 32'h1, "interlock trip");
    rd(OFS_IRQ_STATUS, d, RESP_OKAY);
    chk({31'h0, d[8]}, 32'h1, "status bit");
    wr(OFS_IRQ_STATUS, 32'h0000_0100, RESP_OKAY);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    pulse(1'b1);
    chk({31'h0, alarm_relay_contact_a}, 32'h0, "alarm reset");
    chk({31'h0, trip}, 32'h0, "interlock release");
    pulse(1'b0);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    chk({31'h0, alarm_relay_contact_a}, 32'h0, "alarm after reset");
    rd(OFS_IRQ_MASK, d, RESP_OKAY);
    chk(d, 32'h0, "mask after reset");
    $display("test alarm done");
    wr(OFS_RELAY_CFG, 32'h0003_0005, RESP_OKAY);
    settle();
    chk({30'h0, alarm_relay_contact_a, run_relay_contact_a}, 32'h3, "inverted relays");
    $display("test polarity done");
    wr(OFS_ACCEL_THR_A, 32'h0bb8, RESP_OKAY);
    wr(OFS_DECEL_THR_A, 32'h07d0, RESP_OKAY);
    wr(OFS_ACCEL_THR_B, 32'h0bb8, RESP_OKAY);
    wr(OFS_DECEL_THR_B, 32'h07d0, RESP_OKAY);
    wr(OFS_TERM_SEL, 32'h1f06_0201, RESP_OKAY);
    arrival(1, 2, 0);
    wr(OFS_TERM_SEL, 32'h0103_1413, RESP_OKAY);
    arrival(0, 1, 3);
    $display("test arrival done");
    wr(OFS_TERM_SEL, 32'h0004_1503, RESP_OKAY);
    output_current <= 16'h0065;
    settle();
    chk({28'h0, oc_terminal}, 32'h3, "both overloads");
    wr(OFS_OL_LEVEL_TWO, 32'h14, RESP_OKAY);
    output_current <= 16'h0096;
    settle();
    chk({28'h0, oc_terminal}, 32'h1, "overload one only");
    output_current <= 16'h0063;
    pid_error <= 16'h001f;
    run_mode <= 1;
    settle();
    chk({28'h0, oc_terminal}, 32'hc, "pid over, run");
    pid_error <= 16'hffe1;
    settle();
    chk({28'h0, oc_terminal}, 32'hc, "pid negative");
    pid_error <= 16'h001d;
    run_mode <= 0;
    settle();
    chk({28'h0, oc_terminal}, 32'h0, "pid under, stop");
    $display("test overload pid run done");
    wr(OFS_ACCEL_THR_A, 32'hffff, RESP_OKAY);
    rd(OFS_ACCEL_THR_A, d, RESP_OKAY);
    chk(d, 32'h9c40, "threshold clamp");
    wr(OFS_ACCEL_THR_A, 32'h3039, RESP_OKAY);
    rd(OFS_ACCEL_THR_A, d, RESP_OKAY);
    chk(d, 32'h3034, "coarse step");
    wr(OFS_OL_LEVEL_ONE, 32'hff, RESP_OKAY);
    rd(OFS_OL_LEVEL_ONE, d, RESP_OKAY);
    chk(d, 32'h14, "overload clamp");
    wr(OFS_PID_DEV_LEVEL, 32'hffff, RESP_OKAY);
    rd(OFS_PID_DEV_LEVEL, d, RESP_OKAY);
    chk(d, 32'h3e8, "pid clamp");
    $display("test limits done");
    stop_test();
  end
endmodule
